// file: bldc_ctrl.sv
// phase switch gating, tachometer, soft-start and register file of the motor driver
//
// Our own choices: the register offsets and the plain strobed port.
module bldc_ctrl
    import bldc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic PWM_TRIP,
    input wire logic PEAK_TRIP,
    input wire logic OVERCUR_TRIP,
    input wire logic BRAKE_LOW,
    input wire logic COAST_HIGH,
    input wire logic QUAD_SEL,
    input wire logic HALL_POS_1,
    input wire logic HALL_POS_2,
    input wire logic HALL_POS_3,
    input wire logic SUPPLY_LOW,
    input wire logic SS_BELOW,
    input wire logic REF_OK,
    input wire logic [2:0] COMM_HIGH,
    input wire logic [2:0] COMM_LOW,
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    output logic [2:0] HIGH_ON,
    output logic [2:0] LOW_ON,
    output logic [2:0] HALL_STATE,
    output logic TACH_OUT,
    output logic SS_CLAMP,
    output logic IRQ
);

    localparam int PIN_W = $bits(pin_in_t);
    localparam logic [CNT_W-1:0] OSC_LAST = CNT_W'(OSC_CYCLES - 1);
    localparam logic [CNT_W-1:0] OSC_FULL = CNT_W'(OSC_CYCLES);
    localparam logic [CNT_W-1:0] TACH_LOAD = CNT_W'(TACH_CYCLES);

    pin_in_t pin_raw;
    pin_in_t pin_s;
    pin_in_t pin_prev_reg;

    logic [15:0] ctrl_reg;
    logic [EV_COUNT-1:0] status_reg;
    logic [EV_COUNT-1:0] status_next;
    logic [EV_COUNT-1:0] mask_reg;
    logic [EV_COUNT-1:0] events;
    logic [15:0] rdata_next;

    logic [CNT_W-1:0] osc_cnt_reg;
    logic [CNT_W-1:0] osc_cnt_next;
    logic [CNT_W-1:0] ss_level_reg;
    logic [CNT_W-1:0] ss_level_next;
    logic [CNT_W-1:0] ss_step;
    logic [CNT_W:0] ss_sum;
    logic [CNT_W-1:0] tach_cnt_reg;
    logic [CNT_W-1:0] tach_cnt_next;

    logic [2:0] hall_reg;
    logic [2:0] hall_next;
    logic pwm_latch_reg;
    logic pwm_latch_next;
    logic ss_latch_reg;
    logic ss_latch_next;
    drive_t drive_reg;
    drive_t drive_next;
    mode_t mode;

    // pins gathered into the carrier before crossing into the clock domain
    assign pin_raw.pwm_trip = PWM_TRIP;
    assign pin_raw.peak_trip = PEAK_TRIP;
    assign pin_raw.overcur_trip = OVERCUR_TRIP;
    assign pin_raw.brake_low = BRAKE_LOW;
    assign pin_raw.coast_high = COAST_HIGH;
    assign pin_raw.quad_sel = QUAD_SEL;
    assign pin_raw.hall_pos = {HALL_POS_3, HALL_POS_2, HALL_POS_1};
    assign pin_raw.supply_low = SUPPLY_LOW;
    assign pin_raw.ss_below = SS_BELOW;
    assign pin_raw.ref_ok = REF_OK;

    // every comparator and hall pin is asynchronous to the clock, so the whole bundle
    // crosses together; bits may land one cycle apart, which the slow pins tolerate
    pin_sync #(
        .WIDTH(PIN_W)
    ) u_sync (
        .clk(CLOCK),
        .rst_n(RSTN),
        .async_in(pin_raw),
        .sync_out(pin_s)
    );

    // decoded bus accesses
    // writes to read-only or unmapped addresses match nothing and are dropped
    wire wr_ctrl = WR && (ADDR == ADDR_CTRL);
    wire wr_status = WR && (ADDR == ADDR_STATUS);
    wire wr_mask = WR && (ADDR == ADDR_MASK);
    wire ctrl_enable = ctrl_reg[CTRL_ENABLE];

    // control stays parked until the reference regulates, and whenever software clears the enable bit (set at reset)
    wire active = pin_s.ref_ok && ctrl_enable;
    wire overcur = pin_s.overcur_trip;
    wire fault_any = overcur || pin_s.supply_low;
    wire hall_illegal = (hall_reg == 3'b000) || (hall_reg == 3'b111);

    // oscillator: one cycle start pulse per chopping period
    wire cycle_start = (osc_cnt_reg == OSC_LAST);
    assign osc_cnt_next = cycle_start ? '0 : osc_cnt_reg + 1'b1;

    // ramp reached: the conducting time may not pass the soft-start level
    // compared against the count the latch will serve, so the set at the period edge
    // lasts exactly ss level cycles and a zero level still gives no duty
    wire ss_limit = (osc_cnt_next >= ss_level_reg);

    // output stage mode, coast and faults above brake
    // coast outranks brake so an overvoltage shutdown cannot be overridden by braking
    always_comb
    begin
        if (!active)
            mode = MODE_OFF;
        else if (pin_s.coast_high)
            mode = MODE_COAST;
        else if (overcur || hall_illegal)
            mode = MODE_FAULT;
        else if (pin_s.brake_low)
            mode = MODE_BRAKE;
        else
            mode = MODE_RUN;
    end

    // pwm latch: clear beats set so a trip held over the cycle edge still wins
    // the latch only persists in run mode, so leaving run always restarts from off
    wire pwm_clear = pin_s.pwm_trip || pin_s.peak_trip || ss_limit;
    wire pwm_set = cycle_start && (mode == MODE_RUN);
    assign pwm_latch_next = pwm_clear ? 1'b0 : (pwm_set ? 1'b1 : (pwm_latch_reg && mode == MODE_RUN));

    // switch gating per mode
    always_comb
    begin
        drive_next = '0;
        unique case (mode)
            MODE_OFF:
                drive_next = '0;
            MODE_COAST:
                drive_next = '0;
            MODE_FAULT:
                drive_next = '0;
            MODE_BRAKE:
            begin
                // regime select is not looked at here
                drive_next.high_on = 3'b000;
                drive_next.low_on = 3'b111;
            end
            MODE_RUN:
            begin
                if (pin_s.quad_sel)
                begin
                    drive_next.high_on = COMM_HIGH & {3{pwm_latch_reg}};
                    drive_next.low_on = COMM_LOW & {3{pwm_latch_reg}};
                end
                else
                begin
                    drive_next.high_on = COMM_HIGH;
                    drive_next.low_on = COMM_LOW & {3{pwm_latch_reg}};
                end
            end
        endcase
    end

    // hall change opens a tach pulse; latches frozen for its whole width
    // a change inside the pulse is not lost: it starts a new pulse once this one ends
    wire hall_change = (pin_s.hall_pos != hall_reg);
    // incoming code all low or all high, flagged when it is latched
    wire hall_in_illegal = (pin_s.hall_pos == 3'b000) || (pin_s.hall_pos == 3'b111);
    wire tach_busy = (tach_cnt_reg != '0);
    wire tach_start = pin_s.ref_ok && hall_change && !tach_busy;
    assign hall_next = tach_start ? pin_s.hall_pos : hall_reg;
    assign tach_cnt_next = tach_start ? TACH_LOAD : (tach_busy ? tach_cnt_reg - 1'b1 : '0);

    // soft-start latch: set wins over clear while a fault persists
    // reference loss also sets it, so every power-up starts from an empty ramp
    wire ss_set = fault_any || !pin_s.ref_ok;
    wire ss_clear = pin_s.ss_below && !fault_any;
    assign ss_latch_next = ss_set ? 1'b1 : (ss_clear ? 1'b0 : ss_latch_reg);

    // digital copy of the capacitor ramp, one step per oscillator cycle
    assign ss_step = CNT_W'(ctrl_reg[CTRL_SS_STEP_LSB +: CTRL_SS_STEP_W]);
    assign ss_sum = {1'b0, ss_level_reg} + {1'b0, ss_step};
    always_comb
    begin
        if (ss_latch_reg)
            ss_level_next = '0;
        else if (cycle_start && ss_level_reg < OSC_FULL)
            ss_level_next = (ss_sum > {1'b0, OSC_FULL}) ? OSC_FULL : ss_sum[CNT_W-1:0];
        else
            ss_level_next = ss_level_reg;
    end

    // rising-edge events for the interrupt status
    // a pin already high at reset still gives one edge once it is through the synchroniser, since pin_prev_reg starts low
    assign events[EV_TACH] = tach_start;
    assign events[EV_OVERCUR] = pin_s.overcur_trip && !pin_prev_reg.overcur_trip;
    assign events[EV_UNDERV] = pin_s.supply_low && !pin_prev_reg.supply_low;
    assign events[EV_PEAK] = pin_s.peak_trip && !pin_prev_reg.peak_trip;
    assign events[EV_ILLEGAL] = tach_start && hall_in_illegal;
    assign events[EV_BRAKE] = pin_s.brake_low && !pin_prev_reg.brake_low;
    assign events[EV_COAST] = pin_s.coast_high && !pin_prev_reg.coast_high;

    // write one to clear; a new event in the same cycle survives the clear
    wire [EV_COUNT-1:0] clr_bits = wr_status ? WDATA[EV_COUNT-1:0] : '0;
    assign status_next = (status_reg & ~clr_bits) | events;

    // read words, zero-padded to the bus width
    wire [15:0] status_word = {{(16-EV_COUNT){1'b0}}, status_reg};
    wire [15:0] mask_word = {{(16-EV_COUNT){1'b0}}, mask_reg};
    wire [15:0] level_word = {{(16-CNT_W){1'b0}}, ss_level_reg};
    wire any_high_on = (drive_reg.high_on != 3'b000);
    wire any_low_on = (drive_reg.low_on != 3'b000);
    wire [15:0] state_word = {mode, hall_reg, pin_s.quad_sel, tach_busy, pwm_latch_reg, ss_latch_reg,
                              any_high_on, any_low_on, pin_s.ref_ok, 1'b0};

    // read mux, unmapped addresses read zero
    always_comb
    begin
        rdata_next = 16'h0000;
        if (RD)
        begin
            unique case (ADDR)
                ADDR_CTRL:
                    rdata_next = ctrl_reg;
                ADDR_STATUS:
                    rdata_next = status_word;
                ADDR_MASK:
                    rdata_next = mask_word;
                ADDR_STATE:
                    rdata_next = state_word;
                ADDR_SSLEVEL:
                    rdata_next = level_word;
                default:
                    rdata_next = 16'h0000;
            endcase
        end
    end

    // registers written by software
    // status is write-one-to-clear and handled with the events, not here
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ctrl_reg <= CTRL_RESET;
            mask_reg <= MASK_RESET[EV_COUNT-1:0];
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= WDATA;
            if (wr_mask)
                mask_reg <= WDATA[EV_COUNT-1:0];
        end
    end

    // status, interrupt and read data
    // irq uses the next status so it rises on the same edge as the status bit
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            status_reg <= '0;
            IRQ <= 1'b0;
            RDATA <= 16'h0000;
        end
        else
        begin
            status_reg <= status_next;
            IRQ <= |(status_next & mask_reg);
            RDATA <= rdata_next;
        end
    end

    // oscillator, pwm latch and soft-start state
    // the period counter runs free on the one clock; no second clock is made
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            osc_cnt_reg <= '0;
            pwm_latch_reg <= 1'b0;
            ss_latch_reg <= 1'b1;
            ss_level_reg <= '0;
        end
        else
        begin
            osc_cnt_reg <= osc_cnt_next;
            pwm_latch_reg <= pwm_latch_next;
            ss_latch_reg <= ss_latch_next;
            ss_level_reg <= ss_level_next;
        end
    end

    // hall latches and tachometer
    // pin_prev_reg starts low, the idle level of every edge-detected pin
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            hall_reg <= 3'b000;
            tach_cnt_reg <= '0;
            TACH_OUT <= 1'b0;
            pin_prev_reg <= '0;
        end
        else
        begin
            hall_reg <= hall_next;
            tach_cnt_reg <= tach_cnt_next;
            TACH_OUT <= (tach_cnt_next != '0);
            pin_prev_reg <= pin_s;
        end
    end

    // switch drive and clamp outputs straight from flops
    // drive_reg mirrors the switch outputs for the state read-back
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            drive_reg <= '0;
            HIGH_ON <= 3'b000;
            LOW_ON <= 3'b000;
            HALL_STATE <= 3'b000;
            SS_CLAMP <= 1'b1;
        end
        else
        begin
            drive_reg <= drive_next;
            HIGH_ON <= drive_next.high_on;
            LOW_ON <= drive_next.low_on;
            HALL_STATE <= hall_next;
            SS_CLAMP <= ss_latch_next;
        end
    end

endmodule

// file: bldc_ctrl_assertions.sv
// concurrent checks on the switch gating, tachometer and soft-start ports
module bldc_ctrl_checker
    import bldc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic PWM_TRIP,
    input wire logic PEAK_TRIP,
    input wire logic OVERCUR_TRIP,
    input wire logic BRAKE_LOW,
    input wire logic COAST_HIGH,
    input wire logic QUAD_SEL,
    input wire logic SUPPLY_LOW,
    input wire logic SS_BELOW,
    input wire logic REF_OK,
    input wire logic [2:0] COMM_HIGH,
    input wire logic [2:0] HIGH_ON,
    input wire logic [2:0] LOW_ON,
    input wire logic [2:0] HALL_STATE,
    input wire logic TACH_OUT,
    input wire logic SS_CLAMP
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    logic [12:0] hi_cnt_reg;
    wire hall_ok = (HALL_STATE != 3'b000) && (HALL_STATE != 3'b111);
    wire brake_only = BRAKE_LOW && !COAST_HIGH && !OVERCUR_TRIP && REF_OK;

    // high-time of the tach pulse; pins are slow so 13 bits is ample
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
            hi_cnt_reg <= '0;
        else
            hi_cnt_reg <= TACH_OUT ? hi_cnt_reg + 13'h1 : '0;
    end

    // pins need two sync edges plus the output flop, so causes are held a few cycles first
    chk_coast_all_off: assert property (COAST_HIGH [*4] |=> HIGH_ON == 3'b000 && LOW_ON == 3'b000)
        else $error("coast left a switch on");
    chk_ref_low_off: assert property (!REF_OK [*4] |=> HIGH_ON == 3'b000 && LOW_ON == 3'b000 && SS_CLAMP)
        else $error("switch on before reference good");
    chk_brake_drive: assert property (brake_only [*4] ##0 hall_ok |=> HIGH_ON == 3'b000 && LOW_ON == 3'b111)
        else $error("brake drive pattern wrong");
    chk_illegal_hall_off: assert property (!hall_ok |=> HIGH_ON == 3'b000 && LOW_ON == 3'b000)
        else $error("switch on with illegal hall code");
    chk_tach_width: assert property ($fell(TACH_OUT) |-> hi_cnt_reg == TACH_CYCLES)
        else $error("tach pulse width wrong");
    chk_hall_hold: assert property (TACH_OUT && $past(TACH_OUT) |-> $stable(HALL_STATE))
        else $error("hall latch moved during tach pulse");
    chk_tach_on_change: assert property ($changed(HALL_STATE) |-> $rose(TACH_OUT))
        else $error("hall latch update without tach pulse");
    chk_pwm_clears: assert property ((PWM_TRIP && !BRAKE_LOW) [*5] |=> LOW_ON == 3'b000)
        else $error("low side chopping on after pwm trip");
    chk_peak_full_off: assert property ((PEAK_TRIP && QUAD_SEL && !BRAKE_LOW) [*5] |=> {HIGH_ON, LOW_ON} == 6'h00)
        else $error("switch on after peak trip in full mode");
    chk_half_high_on: assert property ((!QUAD_SEL && PWM_TRIP && !BRAKE_LOW && !COAST_HIGH && !OVERCUR_TRIP
        && REF_OK) [*5] ##0 hall_ok |=> HIGH_ON == $past(COMM_HIGH))
        else $error("high side chopped in half mode");
    chk_fault_clamp: assert property ((SUPPLY_LOW || OVERCUR_TRIP) [*4] |=> SS_CLAMP)
        else $error("clamp not driven on fault");
    chk_overcur_off: assert property (OVERCUR_TRIP [*4] |=> HIGH_ON == 3'b000 && LOW_ON == 3'b000)
        else $error("switch on during overcurrent");
    // the clear acts on pins two sync edges old, so the cause is looked at three edges back
    chk_restart_cond: assert property ($fell(SS_CLAMP) |-> $past(SS_BELOW, 3) && !$past(SUPPLY_LOW, 3)
        && !$past(OVERCUR_TRIP, 3) && $past(REF_OK, 3))
        else $error("clamp released too early");
endmodule

bind bldc_ctrl bldc_ctrl_checker u_chk (.CLOCK, .RSTN, .PWM_TRIP, .PEAK_TRIP, .OVERCUR_TRIP, .BRAKE_LOW,
    .COAST_HIGH, .QUAD_SEL, .SUPPLY_LOW, .SS_BELOW, .REF_OK, .COMM_HIGH, .HIGH_ON, .LOW_ON, .HALL_STATE,
    .TACH_OUT, .SS_CLAMP);

// file: bldc_pkg.sv
// constants, types and register map of the brushless motor chop/brake/soft-start logic
package bldc_pkg;

    // clock and timing
    localparam int CLK_HZ = 20_000_000;
    localparam int TACH_WIDTH_US = 113;
    localparam int TACH_CYCLES = (TACH_WIDTH_US * (CLK_HZ / 1_000_000));
    localparam int OSC_HZ = 14_800;
    localparam int OSC_CYCLES = CLK_HZ / OSC_HZ;
    localparam int CNT_W = 12;

    // register map, byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0c;
    localparam logic [7:0] ADDR_SSLEVEL = 8'h10;

    // reset values
    localparam logic [15:0] CTRL_RESET = 16'h0001;
    localparam logic [15:0] MASK_RESET = 16'h0000;

    // control register fields
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_SS_STEP_LSB = 8;
    localparam int CTRL_SS_STEP_W = 8;

    // event bits of status and mask
    localparam int EV_TACH = 0;
    localparam int EV_OVERCUR = 1;
    localparam int EV_UNDERV = 2;
    localparam int EV_PEAK = 3;
    localparam int EV_ILLEGAL = 4;
    localparam int EV_BRAKE = 5;
    localparam int EV_COAST = 6;
    localparam int EV_COUNT = 7;

    // comparator and sensor pins as one bundle
    typedef struct packed {
        logic pwm_trip;
        logic peak_trip;
        logic overcur_trip;
        logic brake_low;
        logic coast_high;
        logic quad_sel;
        logic [2:0] hall_pos;
        logic supply_low;
        logic ss_below;
        logic ref_ok;
    } pin_in_t;

    // switch drive of the three phases
    typedef struct packed {
        logic [2:0] high_on;
        logic [2:0] low_on;
    } drive_t;

    // output stage mode
    typedef enum logic [4:0] {
        MODE_OFF = 5'b00001,
        MODE_COAST = 5'b00010,
        MODE_FAULT = 5'b00100,
        MODE_BRAKE = 5'b01000,
        MODE_RUN = 5'b10000
    } mode_t;

endpackage

// file: hall_motor_model.sv
// behavioural Hall sensors and commutation decoder at the far side of the driver
module hall_motor_model
    import bldc_pkg::*;
(
    input wire logic [2:0] pos,
    output logic [2:0] hall,
    output logic [2:0] comm_high,
    output logic [2:0] comm_low
);
    timeunit 1ns;
    timeprecision 1ns;
    // gray sequence, one sensor changes per step; pos 6 and 7 give the two illegal codes on command
    always_comb
    begin
        case (pos)
            3'h0: {hall, comm_high, comm_low} = {3'b001, 3'b001, 3'b010};
            3'h1: {hall, comm_high, comm_low} = {3'b011, 3'b001, 3'b100};
            3'h2: {hall, comm_high, comm_low} = {3'b010, 3'b010, 3'b100};
            3'h3: {hall, comm_high, comm_low} = {3'b110, 3'b010, 3'b001};
            3'h4: {hall, comm_high, comm_low} = {3'b100, 3'b100, 3'b001};
            3'h5: {hall, comm_high, comm_low} = {3'b101, 3'b100, 3'b010};
            3'h6: {hall, comm_high, comm_low} = {3'b111, 3'b000, 3'b000};
            default: {hall, comm_high, comm_low} = {3'b000, 3'b000, 3'b000};
        endcase
    end
endmodule

// file: pin_sync.sv
// two flip-flop synchroniser for a bundle of asynchronous pin levels
module pin_sync
    import bldc_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // first stage feeds the second only
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// file: tb.sv
// self-checking bench for the motor driver control logic
module tb
    import bldc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLOCK, RSTN, PWM_TRIP, PEAK_TRIP, OVERCUR_TRIP, BRAKE_LOW, COAST_HIGH, QUAD_SEL;
    logic SUPPLY_LOW, SS_BELOW, REF_OK, WR, RD, TACH_OUT, SS_CLAMP, IRQ;
    logic [2:0] pos, hall, comm_high, comm_low, HIGH_ON, LOW_ON, HALL_STATE;
    logic [7:0] ADDR;
    logic [15:0] WDATA, RDATA;
    int mismatches, compares, n;

    hall_motor_model motor (.pos(pos), .hall(hall), .comm_high(comm_high), .comm_low(comm_low));

    bldc_ctrl dut (.CLOCK, .RSTN, .PWM_TRIP, .PEAK_TRIP, .OVERCUR_TRIP, .BRAKE_LOW, .COAST_HIGH, .QUAD_SEL,
        .HALL_POS_1(hall[0]), .HALL_POS_2(hall[1]), .HALL_POS_3(hall[2]), .SUPPLY_LOW, .SS_BELOW, .REF_OK,
        .COMM_HIGH(comm_high), .COMM_LOW(comm_low), .ADDR, .WDATA, .WR, .RD, .RDATA, .HIGH_ON, .LOW_ON,
        .HALL_STATE, .TACH_OUT, .SS_CLAMP, .IRQ);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge CLOCK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge CLOCK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1 check(RDATA, exp);
    endtask

    task automatic step;
        @(posedge CLOCK);
        #1;
    endtask

    // pin changes need two sync edges and the output flop, six gives margin
    task automatic settle;
        repeat (6) step;
    endtask

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        CLOCK = 1'b0;
        forever #25 CLOCK = ~CLOCK;
    end

    // the whole run is well under 40000 cycles
    initial
    begin
        repeat (60000) @(posedge CLOCK);
        mismatches++;
        give_verdict;
    end

    initial
    begin
        {PWM_TRIP, PEAK_TRIP, OVERCUR_TRIP, BRAKE_LOW, COAST_HIGH, QUAD_SEL, SUPPLY_LOW, REF_OK, WR, RD} = '0;
        {RSTN, pos, ADDR, WDATA, mismatches, compares} = '0;
        SS_BELOW = 1'b1;
        repeat (8) @(posedge CLOCK);
        RSTN <= 1'b1;
        settle;
        check({HIGH_ON, LOW_ON}, 16'h0);
        check(SS_CLAMP, 1'b1);
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_MASK, MASK_RESET);
        rd(8'h20, 16'h0000);
        wr(ADDR_MASK, 16'h0001);
        rd(ADDR_MASK, 16'h0001);
        @(posedge CLOCK) REF_OK <= 1'b1;
        for (n = 0; n < 30 && TACH_OUT !== 1'b1; n++) step;
        check(HALL_STATE, 3'b001);
        // a hall move inside the pulse must wait for the pulse to end
        @(posedge CLOCK) pos <= 3'h1;
        for (n = 1; n < 3000 && TACH_OUT === 1'b1; n++) step;
        check(16'(n), 16'(TACH_CYCLES));
        check(HALL_STATE, 3'b001);
        for (n = 0; n < 10 && TACH_OUT !== 1'b1; n++) step;
        check(HALL_STATE, 3'b011);
        check(IRQ, 1'b1);
        wr(ADDR_STATUS, 16'h0001);
        step;
        check(IRQ, 1'b0);
        // ramp step still zero, so no duty ever reaches the low side
        repeat (3000) step;
        check(LOW_ON, 3'b000);
        check(HIGH_ON, comm_high);
        wr(ADDR_CTRL, 16'hff01);
        for (n = 0; n < 20000 && LOW_ON !== comm_low; n++) step;
        check(LOW_ON, comm_low);
        @(posedge CLOCK) PWM_TRIP <= 1'b1;
        settle;
        check(LOW_ON, 3'b000);
        check(HIGH_ON, comm_high);
        @(posedge CLOCK) QUAD_SEL <= 1'b1;
        settle;
        check(HIGH_ON, 3'b000);
        @(posedge CLOCK) PWM_TRIP <= 1'b0;
        for (n = 0; n < 1400 && LOW_ON !== comm_low; n++) step;
        check(LOW_ON, comm_low);
        check(HIGH_ON, comm_high);
        @(posedge CLOCK) PEAK_TRIP <= 1'b1;
        settle;
        check({HIGH_ON, LOW_ON}, 16'h0);
        @(posedge CLOCK) PEAK_TRIP <= 1'b0;
        @(posedge CLOCK) BRAKE_LOW <= 1'b1;
        settle;
        check({HIGH_ON, LOW_ON}, 16'h0007);
        @(posedge CLOCK) QUAD_SEL <= 1'b0;
        settle;
        check({HIGH_ON, LOW_ON}, 16'h0007);
        @(posedge CLOCK) BRAKE_LOW <= 1'b0;
        @(posedge CLOCK) COAST_HIGH <= 1'b1;
        settle;
        check({HIGH_ON, LOW_ON}, 16'h0);
        @(posedge CLOCK) COAST_HIGH <= 1'b0;
        @(posedge CLOCK) OVERCUR_TRIP <= 1'b1;
        SS_BELOW <= 1'b0;
        settle;
        check({HIGH_ON, LOW_ON}, 16'h0);
        check(SS_CLAMP, 1'b1);
        @(posedge CLOCK) OVERCUR_TRIP <= 1'b0;
        settle;
        check(SS_CLAMP, 1'b1);
        @(posedge CLOCK) SS_BELOW <= 1'b1;
        settle;
        check(SS_CLAMP, 1'b0);
        rd(ADDR_STATUS, 16'h006a);
        @(posedge CLOCK) SUPPLY_LOW <= 1'b1;
        settle;
        check(SS_CLAMP, 1'b1);
        @(posedge CLOCK) SUPPLY_LOW <= 1'b0;
        @(posedge CLOCK) pos <= 3'h6;
        for (n = 0; n < 20 && TACH_OUT !== 1'b1; n++) step;
        settle;
        check({HIGH_ON, LOW_ON}, 16'h0);
        check(IRQ, 1'b1);
        rd(ADDR_STATUS, 16'h007f);
        give_verdict;
    end
endmodule
